// [core/ric_regs.vh]
/*
 * Register offsets, field positions, reset values and timing counts
 * for the reset and interrupt control block.
 * Assumes a 32-bit APB slave, one aligned word per register.
 */
`ifndef RIC_REGS_VH
`define RIC_REGS_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define RIC_OFS_EXT_IRQ_MASK   12'h000
`define RIC_OFS_GEN_IRQ_FLAGS  12'h004
`define RIC_OFS_MCU_CONTROL    12'h008
`define RIC_OFS_TIMER_MASK     12'h00c
`define RIC_OFS_TIMER_FLAGS    12'h010
`define RIC_OFS_STATUS_WORD    12'h014
`define RIC_OFS_RESET_CAUSE    12'h018
`define RIC_OFS_VECTOR         12'h01c

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define RIC_BIT_EXT_IRQ0       6
`define RIC_BIT_TMR_OVF        1
`define RIC_BIT_GIE            7
`define RIC_BIT_SENSE_LO       0
`define RIC_BIT_SENSE_HI       1
`define RIC_BIT_POWERON_RESET_FLAG           0
`define RIC_BIT_EXTERNAL_RESET_FLAG          1

// ---------------------------------------------------------------
// encodings and reset values
// ---------------------------------------------------------------
`define RIC_SENSE_LOW          2'b00
`define RIC_SENSE_RSVD         2'b01
`define RIC_SENSE_FALL         2'b10
`define RIC_SENSE_RISE         2'b11
`define RIC_VEC_RESET          10'h000
`define RIC_VEC_EXT_IRQ0       10'h001
`define RIC_VEC_TMR_OVF        10'h002
`define RIC_RST_BYTE           8'h00

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define RIC_CLK_PERIOD_NS      20
`define RIC_PIN_RST_MIN_NS     50
`define RIC_PIN_RST_CYC        ((`RIC_PIN_RST_MIN_NS + `RIC_CLK_PERIOD_NS - 1) / `RIC_CLK_PERIOD_NS)
`define RIC_TOUT_SLOW_CYC      16384
`define RIC_TOUT_FAST_CYC      16

`endif

// [core/ric_core.v]
/*
 * Reset and interrupt control: merges reset sources, records the
 * cause, stretches reset by a start-up time-out, and dispatches the
 * external and timer interrupts by priority at instruction boundaries.
 * Assumes the core raises instr_boundary between instructions, accepts
 * irq_take as a one-cycle vector request and pulses return_from_irq.
 */
// Implementation choices: the register offsets and register access over APB.
//
// Summary of operation
// - core held in reset while supply is below power-on threshold.
// - expired enabled watchdog resets the core.
// - reset pin low longer than 50 ns resets; driver holds it longer.
// - after reset pin rises, delay timer holds core until time-out.
// - any reset restores registers to initial values, restart at 000.
// - fast-start fuse at 0 selects shortest start-up; fixed variant otherwise.
// - two flags record cause: power-on, external, neither means watchdog.
// - taking an interrupt clears global enable.
// - return from interrupt sets global enable; software may set it too.
// - vectoring clears the serviced interrupt flag.
// - writing 1 to a flag clears it, writing 0 leaves it.
// - flag set while source disabled stays pending until enabled or cleared.
// - flags pend while global enable clear, then served by priority.
// - level interrupt has no flag; requests only while pin level active.
// - entry and return never save or restore the status word.
// - ext_irq0 enabled only with mask bit 6 and global enable set.
// - two sense bits select rising, falling or level for ext_irq0.
// - ext_irq0 pin activity requests even when pin is an output.
// - ext_irq0 service vectors to address 001.
// - mask bits 7 and 5..0 reserved, ignore writes, read zero.
// - sense 00 low level, 01 reserved, 10 falling, 11 rising.
// - ext_irq0 flag set by edge, cleared by vector or write 1, level clears.
`timescale 1ns/1ps
`default_nettype none
`include "ric_regs.vh"

module ric_core #(
	parameter HAS_FAST_START = 1,
	parameter TOUT_SLOW      = `RIC_TOUT_SLOW_CYC,
	parameter TOUT_FAST      = `RIC_TOUT_FAST_CYC
) (
	// clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// reset sources
	input  wire        supply_below_por,
	input  wire        reset_pin_n,
	input  wire        wdt_expired,
	input  wire        wdt_enable,
	input  wire        fast_start_fuse,
	// interrupt sources
	input  wire        ext_irq0_pin,
	input  wire        timer_ovf_event,
	// core handshake
	input  wire        instr_boundary,
	input  wire        return_from_irq,
	output reg         core_reset,
	output reg         irq_take,
	output reg  [9:0]  irq_vector,
	output reg         global_irq_enable,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr
);

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	reg [2:0] rpin_sync_reg;
	reg [2:0] ipin_sync_reg;
	reg       rpin_state_reg;
	reg       ipin_state_reg;
	reg       ipin_prev_reg;
	reg [2:0] por_sync_reg;
	reg       por_state_reg;

	// reset chains start at idle levels so no false source follows reset
	always @(posedge clk) begin
		if (!rst_n) begin
			rpin_sync_reg  <= 3'b111;
			rpin_state_reg <= 1'b1;
			por_sync_reg   <= 3'b000;
			por_state_reg  <= 1'b0;
		end else begin
			rpin_sync_reg <= {rpin_sync_reg[1:0], reset_pin_n};
			por_sync_reg  <= {por_sync_reg[1:0], supply_below_por};
			if (rpin_sync_reg[2] == rpin_sync_reg[1])
				rpin_state_reg <= rpin_sync_reg[2];
			if (por_sync_reg[2] == por_sync_reg[1])
				por_state_reg <= por_sync_reg[2];
		end
		ipin_sync_reg <= {ipin_sync_reg[1:0], ext_irq0_pin};
		if (ipin_sync_reg[2] == ipin_sync_reg[1])
			ipin_state_reg <= ipin_sync_reg[2];
		ipin_prev_reg <= ipin_state_reg;
	end

	// ---------------------------------------------------------------
	// reset merge and start-up time-out
	// ---------------------------------------------------------------
	localparam [1:0] ST_HOLD = 2'd0;
	localparam [1:0] ST_WAIT = 2'd1;
	localparam [1:0] ST_RUN  = 2'd2;

	reg  [1:0]  rst_state_reg;
	reg  [15:0] tout_cnt_reg;
	reg  [1:0]  pin_low_cnt_reg;
	reg         por_seen_reg;
	reg         ext_seen_reg;
	reg         poweron_reset_flag;
	reg         external_reset_flag;
	wire        por_active;
	wire        pin_active;
	wire        wdt_active;
	wire        any_reset;
	wire        fast_sel;
	wire [15:0] tout_len;

	assign por_active = por_state_reg | ~rst_n;
	assign pin_active = (pin_low_cnt_reg >= `RIC_PIN_RST_CYC);
	assign wdt_active = wdt_enable & wdt_expired;
	assign any_reset  = por_active | pin_active | wdt_active;
	assign fast_sel   = (HAS_FAST_START != 0) && !fast_start_fuse;
	assign tout_len   = fast_sel ? TOUT_FAST[15:0] : TOUT_SLOW[15:0];

	always @(posedge clk) begin
		if (!rst_n)
			pin_low_cnt_reg <= 2'd0;
		else if (rpin_state_reg)
			pin_low_cnt_reg <= 2'd0;
		else if (!pin_active)
			pin_low_cnt_reg <= pin_low_cnt_reg + 2'd1;
	end

	always @(posedge clk) begin
		if (por_active) begin
			rst_state_reg <= ST_HOLD;
			tout_cnt_reg  <= 16'd0;
			por_seen_reg  <= 1'b1;
			ext_seen_reg  <= 1'b0;
			core_reset    <= 1'b1;
		end else if (pin_active | wdt_active) begin
			rst_state_reg <= ST_HOLD;
			tout_cnt_reg  <= 16'd0;
			core_reset    <= 1'b1;
			// a later pin or watchdog reset replaces an older power-on cause
			por_seen_reg  <= 1'b0;
			ext_seen_reg  <= pin_active;
		end else begin
			case (rst_state_reg)
			ST_HOLD: begin
				rst_state_reg <= ST_WAIT;
				tout_cnt_reg  <= 16'd0;
			end
			ST_WAIT: begin
				tout_cnt_reg <= tout_cnt_reg + 16'd1;
				if (tout_cnt_reg >= tout_len - 16'd1) begin
					rst_state_reg <= ST_RUN;
					core_reset    <= 1'b0;
				end
			end
			ST_RUN: ;
			default: rst_state_reg <= ST_HOLD;
			endcase
		end
	end

	// cause flags are loaded on every start-up wait cycle until the core is released
	always @(posedge clk) begin
		if (!rst_n) begin
			poweron_reset_flag  <= 1'b0;
			external_reset_flag <= 1'b0;
		end else if (core_reset && rst_state_reg == ST_WAIT && !any_reset) begin
			poweron_reset_flag  <= por_seen_reg;
			external_reset_flag <= ext_seen_reg;
		end
	end

	// ---------------------------------------------------------------
	// registers and interrupt flags
	// ---------------------------------------------------------------
	reg        ext_mask_reg;
	reg [1:0]  sense_reg;
	reg        tmr_mask_reg;
	reg        ext_flag_reg;
	reg        tmr_flag_reg;
	reg        ext_flag_next;
	reg        tmr_flag_next;
	wire       wr_acc;
	wire       edge_hit;
	wire       level_req;
	wire       ext_req;
	wire       tmr_req;
	wire       take_ext;
	wire       take_tmr;

	assign wr_acc    = psel & penable & pwrite;
	assign edge_hit  = (sense_reg == `RIC_SENSE_FALL &&  ipin_prev_reg && !ipin_state_reg) ||
			   (sense_reg == `RIC_SENSE_RISE && !ipin_prev_reg &&  ipin_state_reg);
	assign level_req = (sense_reg == `RIC_SENSE_LOW) && !ipin_state_reg;
	assign ext_req   = ext_mask_reg & (ext_flag_reg | level_req);
	assign tmr_req   = tmr_mask_reg & tmr_flag_reg;
	assign take_ext  = global_irq_enable & instr_boundary & ext_req & !irq_take;
	assign take_tmr  = global_irq_enable & instr_boundary & tmr_req & !ext_req
			   & !irq_take;

	always @* begin
		ext_flag_next = ext_flag_reg;
		if (take_ext)
			ext_flag_next = 1'b0;
		if (wr_acc && paddr == `RIC_OFS_GEN_IRQ_FLAGS && pwdata[`RIC_BIT_EXT_IRQ0])
			ext_flag_next = 1'b0;
		if (edge_hit)
			ext_flag_next = 1'b1;
		if (sense_reg == `RIC_SENSE_LOW || sense_reg == `RIC_SENSE_RSVD)
			ext_flag_next = 1'b0;
		tmr_flag_next = tmr_flag_reg;
		if (take_tmr)
			tmr_flag_next = 1'b0;
		if (wr_acc && paddr == `RIC_OFS_TIMER_FLAGS && pwdata[`RIC_BIT_TMR_OVF])
			tmr_flag_next = 1'b0;
		if (timer_ovf_event)
			tmr_flag_next = 1'b1;
	end

	always @(posedge clk) begin
		if (core_reset) begin
			ext_mask_reg      <= 1'b0;
			sense_reg         <= `RIC_SENSE_LOW;
			tmr_mask_reg      <= 1'b0;
			ext_flag_reg      <= 1'b0;
			tmr_flag_reg      <= 1'b0;
			global_irq_enable <= 1'b0;
			irq_take          <= 1'b0;
			irq_vector        <= `RIC_VEC_RESET;
		end else begin
			ext_flag_reg <= ext_flag_next;
			tmr_flag_reg <= tmr_flag_next;
			irq_take     <= take_ext | take_tmr;
			if (take_ext)
				irq_vector <= `RIC_VEC_EXT_IRQ0;
			else if (take_tmr)
				irq_vector <= `RIC_VEC_TMR_OVF;
			if (wr_acc && paddr == `RIC_OFS_EXT_IRQ_MASK)
				ext_mask_reg <= pwdata[`RIC_BIT_EXT_IRQ0];
			if (wr_acc && paddr == `RIC_OFS_MCU_CONTROL)
				sense_reg <= pwdata[`RIC_BIT_SENSE_HI:`RIC_BIT_SENSE_LO];
			if (wr_acc && paddr == `RIC_OFS_TIMER_MASK)
				tmr_mask_reg <= pwdata[`RIC_BIT_TMR_OVF];
			// only the enable bit lives here; the rest of the status word is
			// the core's own and is never saved or restored on entry/return
			if (take_ext | take_tmr)
				global_irq_enable <= 1'b0;
			else if (return_from_irq)
				global_irq_enable <= 1'b1;
			else if (wr_acc && paddr == `RIC_OFS_STATUS_WORD)
				global_irq_enable <= pwdata[`RIC_BIT_GIE];
		end
	end

	// ---------------------------------------------------------------
	// apb read path
	// ---------------------------------------------------------------
	reg [31:0] rd_mux;
	reg        rd_err;

	always @* begin
		rd_mux = 32'h0000_0000;
		rd_err = 1'b0;
		case (paddr)
		`RIC_OFS_EXT_IRQ_MASK:  rd_mux[`RIC_BIT_EXT_IRQ0] = ext_mask_reg;
		`RIC_OFS_GEN_IRQ_FLAGS: rd_mux[`RIC_BIT_EXT_IRQ0] = ext_flag_reg;
		`RIC_OFS_MCU_CONTROL:   rd_mux[1:0] = sense_reg;
		`RIC_OFS_TIMER_MASK:    rd_mux[`RIC_BIT_TMR_OVF] = tmr_mask_reg;
		`RIC_OFS_TIMER_FLAGS:   rd_mux[`RIC_BIT_TMR_OVF] = tmr_flag_reg;
		`RIC_OFS_STATUS_WORD:   rd_mux[`RIC_BIT_GIE] = global_irq_enable;
		`RIC_OFS_RESET_CAUSE:   rd_mux[1:0] = {external_reset_flag, poweron_reset_flag};
		`RIC_OFS_VECTOR:        rd_mux[9:0] = irq_vector;
		default:                rd_err = 1'b1;
		endcase
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & !penable;
			pslverr <= psel & !penable & rd_err;
			if (psel & !penable & !pwrite)
				prdata <= rd_mux;
			else if (!psel)
				prdata <= 32'h0000_0000;
		end
	end

endmodule
`default_nettype wire

// [verif/ric_core_model.sv]
/*
 * Processor core model: marks instruction boundaries and returns from handlers.
 * Assumes irq_take is a one-cycle pulse from the control block.
 */
`timescale 1ns/1ps
`default_nettype none
module ric_core_model (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic core_reset,
	// bench controls
	input  wire logic slow,
	input  wire logic ret_en,
	// handshake
	input  wire logic irq_take,
	output wire logic instr_boundary,
	output var  logic return_from_irq
);
	logic       busy_reg;
	logic [1:0] phase_reg;
	logic [2:0] wait_reg;

	// slow core gives a boundary every third cycle
	assign instr_boundary = !slow || phase_reg == 2'h0;

	always @(posedge clk) begin
		if (!rst_n || core_reset) begin
			busy_reg <= 1'b0;
			phase_reg <= 2'h0;
			wait_reg <= 3'h0;
			return_from_irq <= 1'b0;
		end else begin
			phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
			return_from_irq <= 1'b0;
			if (irq_take) begin
				busy_reg <= 1'b1;
				wait_reg <= 3'h0;
			end else if (busy_reg && wait_reg != 3'h5) begin
				wait_reg <= wait_reg + 3'h1;
			end else if (busy_reg && ret_en) begin
				// handler ends without restoring the status word
				busy_reg <= 1'b0;
				return_from_irq <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// [verif/ric_core_chk.sv]
/*
 * Assertion checker for the reset and interrupt control block.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module ric_core_chk #(
	parameter TOUT_FAST = 16
) (
	// clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// reset sources
	input wire logic       supply_below_por,
	input wire logic       reset_pin_n,
	input wire logic       wdt_expired,
	input wire logic       wdt_enable,
	// core side
	input wire logic       instr_boundary,
	input wire logic       return_from_irq,
	input wire logic       core_reset,
	input wire logic       irq_take,
	input wire logic [9:0] irq_vector,
	input wire logic       global_irq_enable,
	// apb
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	int unsigned hold_cnt;

	// cycles held in reset since the reset pin was last low
	always @(posedge clk) begin
		if (!rst_n || !core_reset || !reset_pin_n)
			hold_cnt <= 0;
		else
			hold_cnt <= hold_cnt + 1;
	end

	sequence s_setup; psel && !penable; endsequence
	sequence s_take; irq_take; endsequence

	chk_take_gie: assert property (s_take |-> !global_irq_enable)
		else $error("enable still set at take");
	chk_take_vec: assert property (s_take |-> irq_vector inside {10'h001, 10'h002})
		else $error("bad vector");
	chk_take_pulse: assert property (s_take |=> !irq_take)
		else $error("take longer than a cycle");
	chk_take_cause: assert property ($rose(irq_take) |-> $past(instr_boundary) && $past(global_irq_enable))
		else $error("take off boundary or disabled");
	chk_return_from_irq_gie: assert property (return_from_irq && !core_reset |=> global_irq_enable || irq_take)
		else $error("return left enable clear");
	chk_apb_ready: assert property (s_setup |=> pready && penable)
		else $error("no ready in access cycle");
	chk_rst_release: assert property ($rose(rst_n) |-> core_reset [*4])
		else $error("core left reset early");
	chk_por_hold: assert property (supply_below_por [*3] |-> ##[0:4] core_reset)
		else $error("low supply not holding reset");
	chk_pin_hold: assert property (!reset_pin_n [*4] |-> ##[0:6] core_reset)
		else $error("reset pin ignored");
	chk_wdt_reset: assert property (wdt_expired && wdt_enable |-> ##[1:4] core_reset)
		else $error("watchdog ignored");
	chk_startup: assert property ($fell(core_reset) |-> hold_cnt >= TOUT_FAST)
		else $error("start-up shorter than time-out");
	chk_no_take: assert property (core_reset |-> !irq_take)
		else $error("take during reset");
endmodule
bind ric_core ric_core_chk #(.TOUT_FAST(TOUT_FAST)) i_chk (.*);
`default_nettype wire

// [verif/reset_and_interrupt_control_tb_top.sv]
/*
 * Bench top: resets, drives pins and apb, checks registers and takes.
 * Assumes ric_core, the core model and the checker are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ric_regs.vh"
module reset_and_interrupt_control_tb_top;
	logic        clk = 0, rst_n = 0, supply_below_por = 0, reset_pin_n = 1;
	logic        wdt_expired = 0, wdt_enable = 0, fast_start_fuse = 0;
	logic        ext_irq0_pin = 1, timer_ovf_event = 0, slow = 0, ret_en = 0;
	logic        psel = 0, penable = 0, pwrite = 0, e;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q;
	logic        instr_boundary, return_from_irq, core_reset, irq_take;
	logic        global_irq_enable, pready, pslverr;
	logic [9:0]  irq_vector;
	logic [9:0]  vq[$];
	int          n_fail = 0, cmp_count = 0, seed = 95967, cyc = 0, rel = 0;
	localparam int TOUT_S = 32;
	localparam int TOUT_F = 4;

	ric_core #(.TOUT_SLOW(TOUT_S), .TOUT_FAST(TOUT_F)) i_dut (.*);
	ric_core_model i_core (.*);

	always #10 clk = ~clk;

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (irq_take === 1'b1)
			vq.push_back(irq_vector);
		if (cyc == 20000) begin
			n_fail++;
			finish_test();
		end
	end

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask

	task automatic pin(input logic v);
		ext_irq0_pin <= v;
		repeat (8) @(posedge clk);
	endtask

	task automatic restart(input string s);
		rel = 6;
		repeat (6) @(posedge clk);
		while (core_reset !== 1'b0) begin
			@(posedge clk);
			rel++;
		end
		$display("test %s done", s);
	endtask

	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1;
		restart("power-up");
		rd(`RIC_OFS_RESET_CAUSE, 32'h1);
		rd(`RIC_OFS_EXT_IRQ_MASK, 32'h0);
		apb(1'b1, `RIC_OFS_EXT_IRQ_MASK, 32'hffff_ffff);
		rd(`RIC_OFS_EXT_IRQ_MASK, 32'h40);
		apb(1'b0, 12'h020, 32'h0);
		chk({q[30:0], e}, 32'h1);
		for (int s = 2; s < 4; s++) begin
			pin(s == 2);
			apb(1'b1, `RIC_OFS_MCU_CONTROL, s);
			apb(1'b1, `RIC_OFS_GEN_IRQ_FLAGS, 32'h40);
			pin(s != 2);
			rd(`RIC_OFS_GEN_IRQ_FLAGS, 32'h40);
			apb(1'b1, `RIC_OFS_GEN_IRQ_FLAGS, $random(seed) & 32'hffff_ffbf);
			rd(`RIC_OFS_GEN_IRQ_FLAGS, 32'h40);
			apb(1'b1, `RIC_OFS_GEN_IRQ_FLAGS, 32'h40);
			rd(`RIC_OFS_GEN_IRQ_FLAGS, 32'h0);
		end
		$display("test edge done");
		pin(0);
		pin(1);
		apb(1'b1, `RIC_OFS_TIMER_MASK, 32'h2);
		timer_ovf_event <= 1;
		@(posedge clk);
		timer_ovf_event <= 0;
		ret_en <= 1;
		vq.delete();
		apb(1'b1, `RIC_OFS_STATUS_WORD, 32'h80);
		repeat (40) @(posedge clk);
		chk(vq.size(), 2);
		chk({22'h0, vq[0]}, 32'h1);
		chk({22'h0, vq[1]}, 32'h2);
		rd(`RIC_OFS_GEN_IRQ_FLAGS, 32'h0);
		rd(`RIC_OFS_TIMER_FLAGS, 32'h0);
		$display("test priority done");
		ret_en <= 0;
		slow <= 1;
		vq.delete();
		apb(1'b1, `RIC_OFS_MCU_CONTROL, 32'h1);
		pin(0);
		pin(1);
		rd(`RIC_OFS_GEN_IRQ_FLAGS, 32'h0);
		apb(1'b1, `RIC_OFS_MCU_CONTROL, 32'h0);
		pin(0);
		rd(`RIC_OFS_STATUS_WORD, 32'h0);
		rd(`RIC_OFS_GEN_IRQ_FLAGS, 32'h0);
		pin(1);
		ret_en <= 1;
		repeat (20) @(posedge clk);
		chk(vq.size(), 1);
		rd(`RIC_OFS_STATUS_WORD, 32'h80);
		$display("test level done");
		reset_pin_n <= 0;
		repeat (5) @(posedge clk);
		reset_pin_n <= 1;
		restart("pin reset");
		chk(rel < TOUT_S, 1);
		rd(`RIC_OFS_VECTOR, 32'h0);
		rd(`RIC_OFS_RESET_CAUSE, 32'h2);
		rd(`RIC_OFS_EXT_IRQ_MASK, 32'h0);
		rd(`RIC_OFS_STATUS_WORD, 32'h0);
		fast_start_fuse <= 1;
		wdt_enable <= 1;
		wdt_expired <= 1;
		@(posedge clk);
		wdt_expired <= 0;
		wdt_enable <= 0;
		restart("watchdog");
		chk(rel >= TOUT_S, 1);
		rd(`RIC_OFS_RESET_CAUSE, 32'h0);
		supply_below_por <= 1;
		repeat (4) @(posedge clk);
		supply_below_por <= 0;
		restart("supply");
		rd(`RIC_OFS_RESET_CAUSE, 32'h1);
		finish_test();
	end
endmodule
`default_nettype wire
